// File: dv/fifo_host_port_handshake_bench.sv
// Self-checking bench of the FIFO host port.
`timescale 1ns/1ps
module fifo_host_port_handshake_bench;
   logic        mclk_i = 0, rst_i = 1, bus_width_select_i = 1, rx_valid_i = 0, tx_ready_i = 0;
   logic [15:0] rx_data_i = 16'h0000;
   logic        wr_n, rd_n, dma_acknowledge_n_n, cs_n, tc, waited, host_data_oe_o, ready_o, ready_oe_o;
   logic        dma_request_o, rx_ready_o, tx_valid_o, write_busy_o;
   logic [15:0] hd_in, hd_out, tx_data_o, rd, w;
   logic [15:0] rxq[$], txq[$];
   integer      seed = 32, num_errors = 0, comparisons = 0, cyc = 0, cnt = 0, i;
   fifo_host_port uut (.mclk_i, .rst_i, .io_write_strobe_n_i(wr_n), .io_read_strobe_n_i(rd_n),
      .dma_acknowledge_n_i(dma_acknowledge_n_n), .chip_select_n_i(cs_n), .terminal_count_i(tc),
      .bus_width_select_i, .host_data_i(hd_in), .host_data_o(hd_out), .host_data_oe_o,
      .ready_o, .ready_oe_o, .dma_request_o, .rx_valid_i, .rx_ready_o, .rx_data_i,
      .tx_valid_o, .tx_ready_i, .tx_data_o, .write_busy_o);
   host_model host (.mclk_i, .ready_i(ready_o & ready_oe_o), .data_i(hd_out), .wr_n_o(wr_n),
      .rd_n_o(rd_n), .dma_acknowledge_n_n_o(dma_acknowledge_n_n), .cs_n_o(cs_n), .tc_o(tc), .data_o(hd_in));
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp)
         begin
            num_errors = num_errors + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask : chk
   task final_report;
      begin
         $display("comparisons %0d, errors %0d", comparisons, num_errors);
         if (num_errors == 0 && comparisons > 0) $display("No errors found");
         else $display("Errors were found");
         $finish;
      end
   endtask : final_report
   initial forever #50 mclk_i = ~mclk_i;
   always @(posedge mclk_i)
   begin
      cyc = cyc + 1;
      if (cyc == 5000)
      begin
         num_errors = num_errors + 1;
         final_report();
      end
      if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1) chk(tx_data_o, txq.pop_front());
      // Mostly ready, so a write wait is bounded by the recovery and not by the sink.
      #1 tx_ready_i = ($random(seed) & 3) != 0;
   end
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (2) @(posedge mclk_i);
      #1 rst_i = 0;
      repeat (5) @(posedge mclk_i);
      #1 rx_valid_i = 1;
      rx_data_i = $random(seed);
      repeat (30)
      begin
         @(posedge mclk_i);
         if (rx_ready_o === 1'b1)
         begin
            rxq.push_back(rx_data_i);
            cnt = cnt + 1;
         end
         #1 rx_data_i = $random(seed);
      end
      rx_valid_i = 0;
      chk(rx_ready_o, 0);
      chk(cnt >= 16, 1);
      host.sel(0, 1);
      chk(dma_request_o, 1);
      // Even reads leave a one-cycle gap so the next one lands in recovery.
      for (i = 0; i < cnt; i = i + 1)
      begin
         if (i == 2) host.tc_pulse();
         if (i == 4)
         begin
            host.sel(1, 1);
            chk(ready_oe_o, 0);
            host.sel(1, 0);
         end
         if (i == cnt / 2) bus_width_select_i = 0;
         host.xfer(0, 16'h0000, (i % 2 == 0) ? 1 : 12, rd, waited);
         chk(rd, rxq.pop_front());
         chk(waited, i % 2 == 1);
      end
      // Let the last read's recovery end before the writes start.
      repeat (12) @(posedge mclk_i);
      #1;
      // Odd writes follow at once and land in the internal write sequence.
      for (i = 0; i < 6; i = i + 1)
      begin
         bus_width_select_i = i < 2;
         while (i % 2 == 0 && txq.size() != 0)
         begin
            @(posedge mclk_i);
            #1;
         end
         w = $random(seed);
         txq.push_back(w);
         host.xfer(1, w, (i % 2 == 0) ? 1 : 12, rd, waited);
         chk(waited, i % 2 == 1);
      end
      repeat (40) @(posedge mclk_i);
      chk(txq.size(), 0);
      final_report();
   end
endmodule : fifo_host_port_handshake_bench

// File: dv/host_model.sv
// Host bus partner: strobes, select, acknowledge and terminal count.
`timescale 1ns/1ps
module host_model (
   input  wire logic        mclk_i,
   input  wire logic        ready_i,
   input  wire logic [15:0] data_i,
   output logic             wr_n_o,
   output logic             rd_n_o,
   output logic             dma_acknowledge_n_n_o,
   output logic             cs_n_o,
   output logic             tc_o,
   output logic      [15:0] data_o
);
   initial
   begin
      {wr_n_o, rd_n_o, dma_acknowledge_n_n_o, cs_n_o, tc_o} = 5'h1E;
      data_o = 16'h0000;
   end
   task sel(input logic d_n, input logic c_n);
      begin
         dma_acknowledge_n_n_o = d_n;
         cs_n_o = c_n;
         repeat (3) @(posedge mclk_i);
         #1;
      end
   endtask : sel
   task tc_pulse;
      begin
         tc_o = 1;
         repeat (6) @(posedge mclk_i);
         #1 tc_o = 0;
      end
   endtask : tc_pulse
   // Write data turns over as the strobe rises, as a host with no hold time would.
   task xfer(input logic wr, input logic [15:0] wd, input integer gap,
             output logic [15:0] rd, output logic waited);
      integer n;
      begin
         waited = 0;
         n = 0;
         data_o = wd;
         if (wr) wr_n_o = 0;
         else rd_n_o = 0;
         repeat (6)
         begin
            @(posedge mclk_i);
            #1 waited = waited | !ready_i;
         end
         while (ready_i !== 1'b1 && n < 40)
         begin
            @(posedge mclk_i);
            #1 n = n + 1;
         end
         rd = data_i;
         wr_n_o = 1;
         rd_n_o = 1;
         if (wr) data_o = ~wd;
         repeat (gap) @(posedge mclk_i);
         #1;
      end
   endtask : xfer
endmodule : host_model

// File: dv/host_port_chk.sv
// Concurrent checks on the pins of the FIFO host port.
`timescale 1ns/1ps
module host_port_chk (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic io_write_strobe_n_i,
   input wire logic io_read_strobe_n_i,
   input wire logic dma_acknowledge_n_i,
   input wire logic chip_select_n_i,
   input wire logic terminal_count_i,
   input wire logic bus_width_select_i,
   input wire logic host_data_oe_o,
   input wire logic ready_o,
   input wire logic ready_oe_o,
   input wire logic dma_request_o,
   input wire logic write_busy_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   sequence wide_s;
      write_busy_o[*5] ##1 !write_busy_o;
   endsequence
   sequence narrow_s;
      write_busy_o[*3] ##1 !write_busy_o;
   endsequence
   a_busy_wide: assert property ($rose(write_busy_o) && bus_width_select_i |-> wide_s)
      else $error("write sequence length wrong in wide mode");
   a_busy_narrow: assert property ($rose(write_busy_o) && !bus_width_select_i |-> narrow_s)
      else $error("write sequence length wrong in narrow mode");
   a_busy_start: assert property ($rose(io_write_strobe_n_i) && !chip_select_n_i
      |-> ##[2:4] write_busy_o)
      else $error("write sequence did not start");
   a_ready_back: assert property ($fell(ready_o) |-> ##[1:12] ready_o)
      else $error("ready stayed low too long");
   a_oe_off: assert property ((dma_acknowledge_n_i && chip_select_n_i)[*3]
      |-> !ready_oe_o && !host_data_oe_o)
      else $error("pins driven without select");
   a_oe_on: assert property ((!chip_select_n_i)[*3] |-> ready_oe_o)
      else $error("ready not driven under select");
   a_req_tc: assert property (terminal_count_i[*5] |-> !dma_request_o)
      else $error("request kept after terminal count");
   a_req_strobe: assert property ((!dma_acknowledge_n_i && !io_read_strobe_n_i)[*4]
      |-> !dma_request_o)
      else $error("request kept during strobe");
endmodule : host_port_chk

bind fifo_host_port host_port_chk u_chk (.mclk_i, .rst_i, .io_write_strobe_n_i,
   .io_read_strobe_n_i, .dma_acknowledge_n_i, .chip_select_n_i, .terminal_count_i,
   .bus_width_select_i, .host_data_oe_o, .ready_o, .ready_oe_o, .dma_request_o, .write_busy_o);

// File: rtl/fifo_host_port.sv
// Host-side FIFO port with ready handshake, DMA request and recovery timing.
`timescale 1ns/1ps
`include "host_port_defines.svh"
module fifo_host_port #(
   parameter int WIDTH = 16,
   parameter int DEPTH = `FIFO_DEPTH
)
(
   input  wire logic             mclk_i,
   input  wire logic             rst_i,
   input  wire logic             io_write_strobe_n_i,
   input  wire logic             io_read_strobe_n_i,
   input  wire logic             dma_acknowledge_n_i,
   input  wire logic             chip_select_n_i,
   input  wire logic             terminal_count_i,
   input  wire logic             bus_width_select_i,
   input  wire logic [WIDTH-1:0] host_data_i,
   output logic      [WIDTH-1:0] host_data_o,
   output logic                  host_data_oe_o,
   output logic                  ready_o,
   output logic                  ready_oe_o,
   output logic                  dma_request_o,
   input  wire logic             rx_valid_i,
   output logic                  rx_ready_o,
   input  wire logic [WIDTH-1:0] rx_data_i,
   output logic                  tx_valid_o,
   input  wire logic             tx_ready_i,
   output logic      [WIDTH-1:0] tx_data_o,
   output logic                  write_busy_o
);
   ////////////////////////////////////////////////////////////////////////////
   localparam logic [3:0] REC_WIDE   = 4'(`REC_WIDE_CYC);
   localparam logic [3:0] REC_NARROW = 4'(`REC_NARROW_CYC);

   logic [5:0] pins_s;
   logic       wr_n_s;
   logic       rd_n_s;
   logic       ack_n_s;
   logic       cs_n_s;
   logic       tc_s;
   logic       width_s;
   logic       wr_n_d_ff;
   logic       rd_n_d_ff;
   logic       tc_d_ff;
   logic       sel;
   logic       wr_fall;
   logic       wr_rise;
   logic       rd_fall;
   logic       rd_rise;
   logic       tc_rise;
   logic       wait_set;
   logic [3:0] rec_len;

   host_port_pkg::seq_state_type state_ff;
   host_port_pkg::seq_state_type nxt_state;
   logic [3:0]       timer_ff;
   logic             ready_ff;
   logic             wait_ff;
   logic [WIDTH-1:0] pre_ff;
   logic             pre_ok_ff;
   logic             req_ff;
   logic [WIDTH-1:0] wr_data_ff;
   logic             fifo_out_valid;
   logic [WIDTH-1:0] fifo_out_data;
   logic             fifo_pop;
   logic             push_valid_ff;
   logic [WIDTH-1:0] data_s;
   logic [WIDTH-1:0] wr_hold_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Every pin passes two flops before logic reads it.
   sync_two_ff #(.WIDTH(6), .INIT(`PIN_IDLE_LEVELS)) u_sync
   (
      .mclk_i  (mclk_i),
      .rst_i   (rst_i),
      .async_i ({io_write_strobe_n_i, io_read_strobe_n_i, dma_acknowledge_n_i,
                 chip_select_n_i, terminal_count_i, bus_width_select_i}),
      .sync_o  (pins_s)
   );
   assign {wr_n_s, rd_n_s, ack_n_s, cs_n_s, tc_s, width_s} = pins_s;

   sync_two_ff #(.WIDTH(WIDTH)) u_sync_data
   (
      .mclk_i  (mclk_i),
      .rst_i   (rst_i),
      .async_i (host_data_i),
      .sync_o  (data_s)
   );

   // Data is taken while the strobe is low, since the host may drop it as the strobe rises.
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         wr_hold_ff <= '0;
      end
      else if (!wr_n_s)
      begin
         wr_hold_ff <= data_s;
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         wr_n_d_ff <= 1'h1;
         rd_n_d_ff <= 1'h1;
         tc_d_ff   <= 1'h0;
      end
      else
      begin
         wr_n_d_ff <= wr_n_s;
         rd_n_d_ff <= rd_n_s;
         tc_d_ff   <= tc_s;
      end
   end

   assign sel     = !ack_n_s || !cs_n_s;
   assign wr_fall = sel && wr_n_d_ff && !wr_n_s;
   assign wr_rise = !wr_n_d_ff && wr_n_s;
   assign rd_fall = sel && rd_n_d_ff && !rd_n_s;
   assign rd_rise = !rd_n_d_ff && rd_n_s;
   assign tc_rise = tc_s && !tc_d_ff;
   // Recovery is counted in master clock cycles; a slower clock stretches it.
   assign rec_len = (width_s == `WIDTH_SEL_NARROW) ? REC_NARROW : REC_WIDE;

   ////////////////////////////////////////////////////////////////////////////
   // Receive stream feeds the FIFO; the host drains it by reads.
   word_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo
   (
      .mclk_i      (mclk_i),
      .rst_i       (rst_i),
      .in_valid_i  (rx_valid_i),
      .in_ready_o  (rx_ready_o),
      .in_data_i   (rx_data_i),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (fifo_pop),
      .out_data_o  (fifo_out_data)
   );

   // Prefetch whenever the holding word is empty and no write sequence is running.
   assign fifo_pop = !pre_ok_ff && fifo_out_valid && (state_ff != host_port_pkg::ST_WRITE);

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         pre_ff    <= '0;
         pre_ok_ff <= 1'h0;
      end
      else if (fifo_pop)
      begin
         pre_ff    <= fifo_out_data;
         pre_ok_ff <= 1'h1;
      end
      else if (rd_rise && pre_ok_ff && !wait_ff)
      begin
         pre_ok_ff <= 1'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         host_port_pkg::ST_IDLE:
         begin
            if (wr_rise)
            begin
               nxt_state = host_port_pkg::ST_WRITE;
            end
            else if (rd_rise)
            begin
               nxt_state = host_port_pkg::ST_FETCH;
            end
         end
         host_port_pkg::ST_WRITE, host_port_pkg::ST_FETCH:
         begin
            if (timer_ff <= 4'h1 && (state_ff == host_port_pkg::ST_WRITE || pre_ok_ff
                || !fifo_out_valid))
            begin
               nxt_state = host_port_pkg::ST_IDLE;
            end
         end
         default:
         begin
            nxt_state = host_port_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         state_ff <= host_port_pkg::ST_IDLE;
         timer_ff <= 4'h0;
      end
      else
      begin
         state_ff <= nxt_state;
         if (state_ff == host_port_pkg::ST_IDLE && (wr_rise || rd_rise))
         begin
            timer_ff <= rec_len;
         end
         else if (timer_ff != 4'h0)
         begin
            timer_ff <= timer_ff - 4'h1;
         end
      end
   end

   // Write data is captured on the strobe's trailing edge and sent at sequence end.
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         wr_data_ff    <= '0;
         push_valid_ff <= 1'h0;
      end
      else
      begin
         if (wr_rise && state_ff == host_port_pkg::ST_IDLE)
         begin
            wr_data_ff    <= wr_hold_ff;
            push_valid_ff <= 1'h1;
         end
         else if (push_valid_ff && tx_ready_i && state_ff == host_port_pkg::ST_IDLE)
         begin
            push_valid_ff <= 1'h0;
         end
      end
   end
   assign tx_valid_o   = push_valid_ff && (state_ff == host_port_pkg::ST_IDLE);
   assign tx_data_o    = wr_data_ff;
   assign write_busy_o = (state_ff == host_port_pkg::ST_WRITE);

   ////////////////////////////////////////////////////////////////////////////
   // A strobe landing in recovery holds ready low until the sequence ends.
   assign wait_set = (wr_fall || rd_fall) && (state_ff != host_port_pkg::ST_IDLE
                     || (rd_fall && !pre_ok_ff) || (wr_fall && push_valid_ff));

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         wait_ff <= 1'h0;
      end
      else if (wait_set)
      begin
         wait_ff <= 1'h1;
      end
      else if (state_ff == host_port_pkg::ST_IDLE && nxt_state == host_port_pkg::ST_IDLE
               && (pre_ok_ff || rd_n_s) && !push_valid_ff)
      begin
         wait_ff <= 1'h0;
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         ready_ff <= 1'h1;
      end
      else
      begin
         ready_ff <= !wait_ff && !wait_set;
      end
   end
   assign ready_o    = ready_ff;
   assign ready_oe_o = sel;

   // Read data is driven at once when the prefetched word is held.
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         host_data_o <= '0;
      end
      else if (!rd_n_s && pre_ok_ff && !wait_ff)
      begin
         host_data_o <= pre_ff;
      end
   end
   assign host_data_oe_o = sel && !rd_n_s;

   ////////////////////////////////////////////////////////////////////////////
   // The request is set only with acknowledge inactive, so it also rises under programmed I/O.
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         req_ff <= 1'h0;
      end
      else if (tc_rise || (!ack_n_s && (!wr_n_s || !rd_n_s)))
      begin
         req_ff <= 1'h0;
      end
      else if (ack_n_s && (pre_ok_ff || !push_valid_ff) && state_ff == host_port_pkg::ST_IDLE)
      begin
         req_ff <= 1'h1;
      end
   end
   assign dma_request_o = req_ff;
endmodule : fifo_host_port

// File: rtl/sync_two_ff.sv
// Two flip-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ps
module sync_two_ff #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
)
(
   input  wire logic             mclk_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_ff;

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         meta_ff <= INIT;
         sync_o  <= INIT;
      end
      else
      begin
         meta_ff <= async_i;
         sync_o  <= meta_ff;
      end
   end
endmodule : sync_two_ff

// File: rtl/word_fifo.sv
// Flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
)
(
   input  wire logic             mclk_i,
   input  wire logic             rst_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0]    wr_ff;
   logic [AW-1:0]    rd_ff;
   logic [AW:0]      cnt_ff;
   logic             push;
   logic             pop;

   assign in_ready_o  = (cnt_ff != DEPTH[AW:0]);
   assign out_valid_o = (cnt_ff != '0);
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;
   assign out_data_o  = mem_ff[rd_ff];

   always_ff @(posedge mclk_i)
   begin
      if (push)
      begin
         mem_ff[wr_ff] <= in_data_i;
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         wr_ff  <= '0;
         rd_ff  <= '0;
         cnt_ff <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
         end
         if (pop)
         begin
            rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
         end
         cnt_ff <= cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
endmodule : word_fifo

// File: shared/host_port_defines.svh
// Constants of the FIFO host port handshake block.
`ifndef HOST_PORT_DEFINES_SVH
`define HOST_PORT_DEFINES_SVH
`define CLK_PERIOD_NS        100
`define STROBE_MIN_NS        100
`define REC_MIN_NS           450
`define REC_MAX_NS           750
`define NARROW_SAVE_NS       200
`define REC_WIDE_CYC         ((`REC_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REC_NARROW_CYC       ((`REC_MIN_NS - `NARROW_SAVE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WIDTH_SEL_NARROW     1'h0
`define PIN_IDLE_LEVELS      6'h3D
`define FIFO_DEPTH           16
`endif

// File: shared/host_port_pkg.sv
// Types of the FIFO host port handshake block.
package host_port_pkg;
   typedef enum logic [1:0]
   {
      ST_IDLE  = 2'b00,
      ST_WRITE = 2'b01,
      ST_FETCH = 2'b10
   } seq_state_type;
endpackage : host_port_pkg
